// *** verilog/reset_status_defs.svh ***
`ifndef RESET_STATUS_DEFS_SVH
`define RESET_STATUS_DEFS_SVH
`define PC_W 13
`define PC_RESET_VEC 13'h0000
`define PC_IRQ_VEC 13'h0004
`define PC_STEP 13'h0001
`define ADDR_STATUS 2'h0
`define ADDR_CAUSE 2'h1
`define ADDR_CTRL 2'h2
`define STATUS_PWRUP 8'h18
`define CAUSE_POR_VAL 8'h00
`define CAUSE_BROWNOUT_VAL 8'h02
`define CAUSE_KEEP_MASK 8'h03
`define BIT_TIMEOUT 4
`define BIT_POWERDOWN 3
`define BIT_POWERON 1
`define BIT_BROWNOUT 0
`define BIT_IRQ_ENABLE 0
`endif

// *** verilog/reset_status_pkg.sv ***
package reset_status_pkg;
  `include "reset_status_defs.svh"
  typedef enum logic [2:0] {
    ev_none,
    ev_pin_run,
    ev_pin_sleep,
    ev_watchdog_run,
    ev_watchdog_wake,
    ev_irq_wake,
    ev_brownout
  } reset_event_t;
  typedef struct packed {
    logic pin_rst;
    logic watchdog_rst;
    logic irq_wake;
    logic brownout;
  } cause_in_t;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : reset_status_pkg

// *** verilog/cause_sync.sv ***
`timescale 1ns/1ps
module cause_sync
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire reset_status_pkg::cause_in_t async_in,
  output reset_status_pkg::cause_in_t sync_out
);
  import reset_status_pkg::*;
  cause_in_t stage1;
  // Stage one feeds stage two only
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : cause_sync

// *** verilog/reset_status_init.sv ***
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Pin reset while running: pc zero, upper three status bits cleared, rest kept.
// - Pin reset in sleep: pc zero, timeout set, powerdown cleared, bank bits cleared.
// - Interrupt wake: resume at pc plus one, timeout set, powerdown cleared.
// - Interrupt wake with irq enable: run next instruction, then jump to vector.
// - Non-power resets other than watchdog wake clear upper three bits, timeout/powerdown by cause.
`include "reset_status_defs.svh"
module reset_status_init
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic brownout_n,
  input wire reset_status_pkg::cause_in_t cause_pins,
  input wire logic in_sleep,
  input wire logic [`PC_W-1:0] sleep_pc,
  input wire logic [7:0] status_in,
  input wire reset_status_pkg::reg_req_t req,
  output logic [7:0] rdata,
  output logic [`PC_W-1:0] pc_load,
  output logic pc_load_valid,
  output logic [7:0] cpu_status_flags,
  output logic [7:0] reset_cause_flags
);
  import reset_status_pkg::*;
  cause_in_t cause;
  cause_in_t cause_q;
  logic global_irq_enable;
  logic irq_pending;
  logic sleep_q;
  reset_event_t ev;
  logic [7:0] next_status;
  logic [7:0] next_cause;
  logic [`PC_W-1:0] next_pc;
  logic brownout_meta_n;
  logic brownout_sync_n;
  logic brownout_q_n;
  cause_sync u_sync
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .async_in(cause_pins),
    .sync_out(cause)
  );
  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction : rise
  // Supply monitor pin, idle high; stages reset high so no edge appears after power-on
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      brownout_meta_n <= 1'b1;
      brownout_sync_n <= 1'b1;
      brownout_q_n <= 1'b1;
    end
    else if (ce)
    begin
      brownout_meta_n <= brownout_n;
      brownout_sync_n <= brownout_meta_n;
      brownout_q_n <= brownout_sync_n;
    end
  end
  // Priority: brown-out over watchdog over pin over interrupt
  always_comb
  begin
    ev = ev_none;
    if (rise(cause.brownout, cause_q.brownout) || rise(~brownout_sync_n, ~brownout_q_n))
      ev = ev_brownout;
    else if (rise(cause.watchdog_rst, cause_q.watchdog_rst))
      ev = sleep_q ? ev_watchdog_wake : ev_watchdog_run;
    else if (rise(cause.pin_rst, cause_q.pin_rst))
      ev = sleep_q ? ev_pin_sleep : ev_pin_run;
    else if (rise(cause.irq_wake, cause_q.irq_wake) && sleep_q)
      ev = ev_irq_wake;
  end
  always_comb
  begin
    next_status = cpu_status_flags;
    next_cause = reset_cause_flags;
    next_pc = `PC_RESET_VEC;
    unique case (ev)
      ev_none: next_pc = pc_load;
      ev_pin_run: next_status = {3'b000, cpu_status_flags[4:0]};
      ev_pin_sleep: next_status = {3'b000, 2'b10, cpu_status_flags[2:0]};
      // Powerdown is left as it was: only timeout tells a watchdog reset apart
      ev_watchdog_run: next_status = {3'b000, 1'b0, cpu_status_flags[3:0]};
      ev_watchdog_wake:
      begin
        next_status = {cpu_status_flags[7:5], 2'b00, cpu_status_flags[2:0]};
        next_pc = sleep_pc + `PC_STEP;
      end
      ev_irq_wake:
      begin
        next_status = {cpu_status_flags[7:5], 2'b10, cpu_status_flags[2:0]};
        next_pc = sleep_pc + `PC_STEP;
      end
      ev_brownout:
      begin
        // Arithmetic bits are undefined here; keeping them keeps X out of the core
        next_status = {`STATUS_PWRUP & 8'hF8} | (cpu_status_flags & 8'h07);
        next_cause = `CAUSE_BROWNOUT_VAL;
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cause_q <= '0;
    else if (ce)
      cause_q <= cause;
  end
  // Sleep is same-clock core logic, no synchroniser
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      sleep_q <= 1'b0;
    else if (ce)
      sleep_q <= in_sleep;
  end
  // rstn is the power-on reset
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cpu_status_flags <= `STATUS_PWRUP;
      reset_cause_flags <= `CAUSE_POR_VAL;
    end
    else if (ce)
    begin
      if (ev != ev_none)
        cpu_status_flags <= next_status;
      else if (req.wr && req.addr == `ADDR_STATUS)
        cpu_status_flags <= {req.wdata[7:5], cpu_status_flags[4:3], req.wdata[2:0]};
      else
        cpu_status_flags <= {cpu_status_flags[7:3], status_in[2:0]};
      if (ev == ev_brownout)
        reset_cause_flags <= next_cause;
      else if (req.wr && req.addr == `ADDR_CAUSE)
        reset_cause_flags <= req.wdata & `CAUSE_KEEP_MASK;
    end
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      global_irq_enable <= 1'b0;
    else if (ce && req.wr && req.addr == `ADDR_CTRL)
      global_irq_enable <= req.wdata[`BIT_IRQ_ENABLE];
  end
  // Vector after the wake instruction executes
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_load <= `PC_RESET_VEC;
      pc_load_valid <= 1'b1;
      irq_pending <= 1'b0;
    end
    else if (ce)
    begin
      // A reset event in the vector cycle cancels the pending jump
      if (irq_pending && ev == ev_none)
      begin
        pc_load <= `PC_IRQ_VEC;
        pc_load_valid <= 1'b1;
        irq_pending <= 1'b0;
      end
      else
      begin
        pc_load <= next_pc;
        pc_load_valid <= (ev != ev_none);
        irq_pending <= (ev == ev_irq_wake) && global_irq_enable;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else if (ce)
    begin
      rdata <= 8'h00;
      if (req.rd)
        unique case (req.addr)
          `ADDR_STATUS: rdata <= cpu_status_flags;
          `ADDR_CAUSE: rdata <= reset_cause_flags;
          `ADDR_CTRL: rdata <= {7'h00, global_irq_enable};
          default: rdata <= 8'h00;
        endcase
    end
  end
  pin_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && ev == ev_pin_run |=> cpu_status_flags[7:5] == 3'b000 && pc_load == `PC_RESET_VEC)
    else $error("pin reset status wrong");
  pin_sleep_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && ev == ev_pin_sleep |=> cpu_status_flags[7:3] == 5'h02 && pc_load == `PC_RESET_VEC)
    else $error("pin sleep status wrong");
  irq_wake_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && ev == ev_irq_wake |=> pc_load == $past(sleep_pc) + `PC_STEP
      && cpu_status_flags[4:3] == 2'b10)
    else $error("irq wake wrong");
  irq_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && ev == ev_irq_wake && !(req.wr && req.addr == `ADDR_CAUSE)
      |=> $stable(reset_cause_flags) && cpu_status_flags[7:5] == $past(cpu_status_flags[7:5]))
    else $error("irq wake changed flags");
  irq_vector_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && ev == ev_irq_wake && global_irq_enable ##1 ce && ev == ev_none
      |=> pc_load == `PC_IRQ_VEC && pc_load_valid)
    else $error("vector not taken");
  watchdog_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && ev == ev_watchdog_run |=> cpu_status_flags[7:4] == 4'h0
      && cpu_status_flags[3] == $past(cpu_status_flags[3]))
    else $error("watchdog status wrong");
  brownout_flags_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && ev == ev_brownout
      |=> reset_cause_flags == `CAUSE_BROWNOUT_VAL && cpu_status_flags[7:3] == 5'h03)
    else $error("brownout flags wrong");
  cause_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && ev == ev_pin_run && !(req.wr && req.addr == `ADDR_CAUSE) |=> $stable(reset_cause_flags))
    else $error("cause changed on pin reset");
  pc_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && (ev == ev_brownout || ev == ev_watchdog_run) |=> pc_load == `PC_RESET_VEC && pc_load_valid)
    else $error("pc not zero");
  ce_freeze_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !ce |=> $stable(cpu_status_flags) && $stable(reset_cause_flags) && $stable(pc_load))
    else $error("state moved with enable low");
  cov_pin_c: cover property (@(posedge core_clk) ev == ev_pin_sleep);
  cov_irq_c: cover property (@(posedge core_clk) ev == ev_irq_wake && global_irq_enable);
  cov_brownout_c: cover property (@(posedge core_clk) ev == ev_brownout);
  cov_watchdog_c: cover property (@(posedge core_clk) ev == ev_watchdog_wake);
endmodule : reset_status_init

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import reset_status_pkg::*;
  logic core_clk;
  logic rstn;
  logic in_sleep;
  logic ce;
  logic brownout_n;
  logic pc_load_valid;
  logic [12:0] sleep_pc;
  logic [12:0] pc_load;
  logic [7:0] rdata;
  logic [7:0] cpu_status_flags;
  logic [7:0] reset_cause_flags;
  cause_in_t cause_pins;
  reg_req_t req;
  int err_count;
  int check_count;
  logic [12:0] pc;
  logic [13:0] nxt;
  logic [7:0] v;
  // Low status bits come from the core, held fixed so expectations stay simple
  reset_status_init reset_status_init_inst
  (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .brownout_n(brownout_n), .cause_pins(cause_pins),
    .in_sleep(in_sleep), .sleep_pc(sleep_pc), .status_in(8'h05), .req(req), .rdata(rdata),
    .pc_load(pc_load), .pc_load_valid(pc_load_valid), .cpu_status_flags(cpu_status_flags),
    .reset_cause_flags(reset_cause_flags)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req <= '0;
    #1 d = rdata;
  endtask : rd
  // Raises one cause, returns the loaded pc and what follows one cycle later
  task automatic fire(input logic [3:0] m, input logic sleep);
    int i;
    @(posedge core_clk);
    in_sleep <= sleep;
    cause_pins <= m;
    i = 0;
    do
    begin
      @(posedge core_clk);
      #1 i++;
    end while (pc_load_valid !== 1'b1 && i < 10);
    if (i >= 10)
    begin
      err_count++;
      tally_and_finish();
    end
    pc = pc_load;
    @(posedge core_clk);
    #1 nxt = {pc_load_valid, pc_load};
    @(posedge core_clk);
    cause_pins <= '0;
    in_sleep <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : fire
  task automatic t_por_regs();
    @(posedge core_clk);
    #1 chk(cpu_status_flags[7:3], 16'h03);
    rd(2'h1, v);
    chk(v, 8'h00);
    wr(2'h0, 8'hFF);
    wr(2'h1, 8'h01);
    rd(2'h0, v);
    chk(v[7:3], 16'h1F);
    rd(2'h3, v);
    chk(v, 8'h00);
    $display("done power-on and registers");
  endtask : t_por_regs
  task automatic t_pin();
    fire(4'b1000, 1'b0);
    chk(pc, 16'h0000);
    chk(nxt[13], 16'h0000);
    chk(cpu_status_flags, 8'h1D);
    chk(reset_cause_flags, 8'h01);
    wr(2'h0, 8'hE0);
    fire(4'b1000, 1'b1);
    chk(pc, 16'h0000);
    chk(cpu_status_flags, 8'h15);
    chk(reset_cause_flags, 8'h01);
    $display("done pin resets");
  endtask : t_pin
  task automatic t_irq();
    wr(2'h2, 8'h01);
    wr(2'h0, 8'hE0);
    fire(4'b0010, 1'b1);
    chk(pc, 16'h0124);
    chk(nxt, 14'h2004);
    chk(cpu_status_flags, 8'hF5);
    chk(reset_cause_flags, 8'h01);
    $display("done interrupt wake");
  endtask : t_irq
  task automatic t_watchdog_brownout();
    wr(2'h0, 8'hE0);
    fire(4'b0001, 1'b0);
    chk(pc, 16'h0000);
    chk(cpu_status_flags[7:3], 16'h03);
    chk(reset_cause_flags, 8'h02);
    // Powerdown is set here, so a watchdog reset must visibly keep it
    fire(4'b0100, 1'b0);
    chk(pc, 16'h0000);
    chk(cpu_status_flags, 8'h0D);
    chk(reset_cause_flags, 8'h02);
    fire(4'b0100, 1'b1);
    chk(pc, 16'h0124);
    chk(cpu_status_flags, 8'h05);
    wr(2'h1, 8'h00);
    @(posedge core_clk);
    brownout_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1 chk(cpu_status_flags, 8'h1D);
    chk(reset_cause_flags, 8'h02);
    @(posedge core_clk);
    brownout_n <= 1'b1;
    $display("done watchdog and brown-out");
  endtask : t_watchdog_brownout
  task automatic t_freeze_por();
    @(posedge core_clk);
    ce <= 1'b0;
    wr(2'h1, 8'h01);
    #1 chk(reset_cause_flags, 8'h02);
    @(posedge core_clk);
    ce <= 1'b1;
    rstn <= 1'b0;
    @(posedge core_clk);
    #1 chk({pc_load_valid, pc_load}, 16'h2000);
    chk(cpu_status_flags, 8'h18);
    @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1 chk(cpu_status_flags[7:3], 16'h03);
    chk(reset_cause_flags, 8'h00);
    $display("done clock enable and second power-on");
  endtask : t_freeze_por
  initial
  begin
    rstn = 1'b0;
    in_sleep = 1'b0;
    ce = 1'b1;
    brownout_n = 1'b1;
    sleep_pc = 13'h0123;
    cause_pins = '0;
    req = '0;
    err_count = 0;
    check_count = 0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    t_por_regs();
    t_pin();
    t_irq();
    t_watchdog_brownout();
    t_freeze_por();
    tally_and_finish();
  end
endmodule : tb
